/* File: uhie_top.sv */
// uhie_top: interrupt enable masking and frame index counter, apb slave
//
// Summary of operation
// (R1) irq only when enabled source active
// (R2) disabled sources still set their status flags
// (R3) async advance irq waits for threshold
// (R4) system error irq raised at once
// (R5) rollover irq raised at once
// (R6) port change irq raised at once
// (R7) transfer error irq waits for threshold
// (R8) transfer done irq waits for threshold
// (R9) clearing status flag drops its irq
// (R10) software writes reserved bits as zero
// (R11) frame index steps every 125 us
// (R12) index bits n..3 select list entry
// (R13) software writes frame index as words
// (R14) frame index writable only while halted
// (R15) software never writes index while running
// (R16) written index changes sof frame number
// (R17) n is 12, 11, 10 by size
// (R18) fourteen bits; bits 13..3 give sof
// (R19) rollover flag set on list index wrap
// (R20) threshold tick counts whole microframes
// (R21) irq is or of eligible sources
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module uhie_top
  import uhie_pkg::*;
#(
  parameter int UFRAME_CYCLES = UFRAME_CYCLES_DFLT  // cycles per microframe
) (
  input  wire logic              clk,                 // controller clock
  input  wire logic              reset,               // async, active high
  input  wire logic              psel,                // apb select
  input  wire logic              penable,             // apb access phase
  input  wire logic              pwrite,              // apb direction
  input  wire logic [ADDR_W-1:0] paddr,               // apb byte address
  input  wire logic [31:0]       pwdata,              // apb write data
  output logic [31:0]            prdata,              // apb read data
  output logic                   pready,              // apb ready
  output logic                   pslverr,             // apb error
  input  wire logic              async_advance_evt,   // schedule advanced
  input  wire logic              system_error_evt,    // host access error
  input  wire logic              port_change_evt,     // port changed
  input  wire logic              transfer_error_evt,  // transaction error
  input  wire logic              transfer_done_evt,   // transaction complete
  output logic                   host_irq,            // host interrupt
  output logic [9:0]             list_index,          // periodic list entry
  output logic [10:0]            sof_frame_number     // sof frame number
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  irq_en;          // interrupt_enable bits 5..0
    logic [5:0]  flags;           // host_status bits 5..0
    logic [5:0]  armed;           // deferred source passed a threshold
    logic        run_stop;        // run control
    logic [1:0]  list_size_sel;   // frame list size
    logic [7:0]  thresh;          // threshold in microframes
    logic        halted_flag;     // controller halted
    logic [13:0] frame_index;     // frame index counter
    logic [9:0]  list_idx;        // registered list entry index
    logic [10:0] sof_num;         // registered sof frame number
    logic [31:0] rdata;           // registered read data
    logic        irq;             // registered interrupt
  } uhie_state_s;

  uhie_state_s st_q;              // registered state
  uhie_state_s st_d;              // next state

  logic        setup_rd;          // read setup phase
  logic        access_wr;         // write access phase
  logic        addr_hit;          // address is mapped
  logic [5:0]  ev_set;            // hardware set vector
  logic [5:0]  sw_clr;            // software clear vector
  logic        advancing;         // counter may step
  logic        uf_tick;           // microframe boundary
  logic        thr_tick;          // interrupt threshold boundary
  logic [7:0]  thr_last;          // threshold terminal count
  logic [13:0] fidx_inc;          // frame index plus one
  logic        roll_evt;          // list index wrapped
  logic        fidx_wr;           // accepted frame index write
  logic [31:0] rd_mux;            // read data selection

  // ---------------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------------

  // zero wait states: every access completes in its first access cycle
  assign pready    = 1'b1;
  assign setup_rd  = psel && !penable && !pwrite;
  assign access_wr = psel && penable && pwrite;
  assign addr_hit  = (paddr == OFS_COMMAND) || (paddr == OFS_STATUS) ||
                     (paddr == OFS_INTR_EN) || (paddr == OFS_FRAME_IDX);
  // unmapped addresses answer with an error and change nothing
  assign pslverr   = psel && penable && !addr_hit;
  assign prdata    = st_q.rdata;

  // read mux; reserved bits read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_COMMAND: begin
        rd_mux[BIT_RUN_STOP]       = st_q.run_stop;
        rd_mux[LSS_LSB +: 2]       = st_q.list_size_sel;
        rd_mux[THR_LSB +: 8]       = st_q.thresh;
      end
      OFS_STATUS: begin
        rd_mux[SRC_N-1:0]          = st_q.flags;
        rd_mux[BIT_HALTED]         = st_q.halted_flag;
      end
      OFS_INTR_EN: begin
        rd_mux[SRC_N-1:0]          = st_q.irq_en;
      end
      OFS_FRAME_IDX: begin
        rd_mux[FIDX_W-1:0]         = st_q.frame_index;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // microframe and threshold timing
  // ---------------------------------------------------------------------------

  // the counter only steps while running and not yet reported halted
  assign advancing = st_q.run_stop && !st_q.halted_flag;

  // microframe divider, restarted whenever the controller halts
  uhie_tick_div #(
    .W      (UFRAME_CNT_W)
  ) u_uframe_div (
    .clk    (clk),
    .reset  (reset),
    .clear  (!advancing),
    .enable (advancing),
    .last   (UFRAME_CNT_W'(UFRAME_CYCLES - 1)),
    .tick   (uf_tick)
  );

  // a zero threshold setting is taken as one microframe
  assign thr_last = (st_q.thresh == 8'h00) ? 8'h00 : st_q.thresh - 8'h01;

  // threshold counts microframe ticks [R20]
  uhie_tick_div #(
    .W      (8)
  ) u_thresh_div (
    .clk    (clk),
    .reset  (reset),
    .clear  (!advancing),
    .enable (uf_tick),
    .last   (thr_last),
    .tick   (thr_tick)
  );

  // ---------------------------------------------------------------------------
  // frame index stepping and rollover
  // ---------------------------------------------------------------------------
  assign fidx_inc = st_q.frame_index + 14'h0001;

  // wrap of the list index shows as a toggle of the bit above n [R19]
  always_comb begin
    roll_evt = 1'b0;
    if (uf_tick) begin
      case (st_q.list_size_sel)
        LSS_1024: begin
          roll_evt = st_q.frame_index[ROLL_BIT_1024] != fidx_inc[ROLL_BIT_1024];
        end
        LSS_512: begin
          roll_evt = st_q.frame_index[ROLL_BIT_512] != fidx_inc[ROLL_BIT_512];
        end
        default: begin
          roll_evt = st_q.frame_index[ROLL_BIT_256] != fidx_inc[ROLL_BIT_256];
        end
      endcase
    end
  end

  // writes land only while halted; others are dropped [R14]
  assign fidx_wr = access_wr && (paddr == OFS_FRAME_IDX) && st_q.halted_flag;

  // ---------------------------------------------------------------------------
  // event and clear vectors
  // ---------------------------------------------------------------------------
  always_comb begin
    ev_set                = 6'h00;
    ev_set[BIT_ASYNC_ADV] = async_advance_evt;
    ev_set[BIT_SYS_ERR]   = system_error_evt;
    ev_set[BIT_ROLLOVER]  = roll_evt;
    ev_set[BIT_PORT_CHG]  = port_change_evt;
    ev_set[BIT_XFER_ERR]  = transfer_error_evt;
    ev_set[BIT_XFER_DONE] = transfer_done_evt;
  end

  // status bits are write-one-to-clear
  assign sw_clr = (access_wr && (paddr == OFS_STATUS)) ? pwdata[SRC_N-1:0] : 6'h00;

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;

    // flags set regardless of enable; a set beats a clear [R2] [R9]
    st_d.flags = (st_q.flags & ~sw_clr) | ev_set;

    // deferred sources arm at a threshold, disarm with their flag [R3] [R7] [R8]
    st_d.armed = st_q.armed;
    if (thr_tick) begin
      st_d.armed = st_q.armed | (st_q.flags & st_q.irq_en & DEFER_MASK);
    end
    st_d.armed = st_d.armed & st_d.flags;

    // enable register; reserved bits are not stored
    if (access_wr && (paddr == OFS_INTR_EN)) begin
      st_d.irq_en = pwdata[SRC_N-1:0];
    end

    // command register
    if (access_wr && (paddr == OFS_COMMAND)) begin
      st_d.run_stop      = pwdata[BIT_RUN_STOP];
      st_d.list_size_sel = pwdata[LSS_LSB +: 2];
      st_d.thresh        = pwdata[THR_LSB +: 8];
    end
    // a system error stops execution, beating a software run
    if (system_error_evt) begin
      st_d.run_stop = 1'b0;
    end

    // halted follows run control one cycle later
    st_d.halted_flag = !st_q.run_stop;

    // frame index: load while halted, else step each microframe [R11] [R16]
    if (fidx_wr) begin
      st_d.frame_index = pwdata[FIDX_W-1:0];
    end else if (uf_tick) begin
      st_d.frame_index = fidx_inc;
    end

    // list entry index from bits n..3, with the size that now holds [R12] [R17]
    case (st_d.list_size_sel)
      LSS_1024: begin
        st_d.list_idx = st_d.frame_index[12:3];
      end
      LSS_512: begin
        st_d.list_idx = {1'b0, st_d.frame_index[11:3]};
      end
      default: begin
        st_d.list_idx = {2'b00, st_d.frame_index[10:3]};
      end
    endcase

    // sof number from bits 13..3 [R18] [R16]
    st_d.sof_num = st_d.frame_index[13:3];

    // capture read data in the setup phase
    if (setup_rd) begin
      st_d.rdata = rd_mux;
    end

    // or of enabled sources, deferred ones once armed [R1] [R4] [R5] [R6] [R21]
    st_d.irq = |(st_d.flags & st_d.irq_en & (IMMED_MASK | st_d.armed));
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q.irq_en        <= INTR_EN_RST;
      st_q.flags         <= FLAGS_RST;
      st_q.armed         <= 6'h00;
      st_q.run_stop      <= RUN_RST;
      st_q.list_size_sel <= LSS_RST;
      st_q.thresh        <= THRESH_RST;
      st_q.halted_flag   <= HALTED_RST;
      st_q.frame_index   <= FIDX_RST;
      st_q.list_idx      <= 10'h000;
      st_q.sof_num       <= 11'h000;
      st_q.rdata         <= 32'h0000_0000;
      st_q.irq           <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs
  assign host_irq         = st_q.irq;
  assign list_index       = st_q.list_idx;
  assign sof_frame_number = st_q.sof_num;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // a step opportunity: microframe boundary with no load
  sequence s_step;
    uf_tick && !fidx_wr;
  endsequence

  // a status write clearing a bit with no new event
  sequence s_ack(int b);
    access_wr && (paddr == OFS_STATUS) && pwdata[b] && !ev_set[b];
  endsequence

  AST_IRQ_NEEDS_SOURCE: assert property ( // [R1]
    host_irq |-> |(st_q.flags & st_q.irq_en))
    else $error("irq without an enabled active source");

  AST_MASKED_FLAG_SETS: assert property ( // [R2]
    (port_change_evt && !st_q.irq_en[BIT_PORT_CHG]) |=> st_q.flags[BIT_PORT_CHG])
    else $error("masked event did not set its flag");

  AST_DEFER_WAITS: assert property ( // [R3] [R7] [R8]
    (host_irq && !(|(st_q.flags & st_q.irq_en & IMMED_MASK)))
      |-> |(st_q.flags & st_q.irq_en & st_q.armed))
    else $error("deferred source raised irq before threshold");

  AST_IMMEDIATE_IRQ: assert property ( // [R4] system error source only
    (system_error_evt && st_q.irq_en[BIT_SYS_ERR] &&
     !(access_wr && (paddr == OFS_INTR_EN))) |=> host_irq)
    else $error("immediate source did not raise irq next cycle");

  AST_ACK_CLEARS: assert property ( // [R9]
    s_ack(BIT_SYS_ERR) |=> !st_q.flags[BIT_SYS_ERR])
    else $error("acknowledged flag stayed set");

  AST_INDEX_STEPS: assert property ( // [R11]
    s_step |=> (st_q.frame_index == $past(st_q.frame_index) + 14'h0001))
    else $error("frame index did not step at microframe");

  AST_INDEX_HOLDS: assert property ( // [R11] [R14]
    (!uf_tick && !fidx_wr) |=> $stable(st_q.frame_index))
    else $error("frame index changed without tick or accepted write");

  AST_WRITE_LOADS: assert property ( // [R14] [R16]
    fidx_wr |=> (st_q.frame_index == $past(pwdata[13:0])) ##1
                (sof_frame_number == $past(pwdata[13:3], 2)))
    else $error("halted write did not reach index and sof number");

  AST_LIST_INDEX: assert property ( // [R12] [R17]
    (st_q.list_size_sel == LSS_256) |-> (list_index[9:8] == 2'b00) &&
      (list_index[7:0] == st_q.frame_index[10:3]))
    else $error("list index not taken from bits 10..3");

  AST_ROLLOVER: assert property ( // [R19]
    (uf_tick && (st_q.list_size_sel == LSS_1024) &&
     (st_q.frame_index[12:0] == 13'h1fff)) |=> st_q.flags[BIT_ROLLOVER])
    else $error("rollover flag not set on list wrap");

  AST_THRESH_ON_UFRAME: assert property ( // [R20]
    thr_tick |-> uf_tick)
    else $error("threshold tick off a microframe boundary");

endmodule : uhie_top

`default_nettype wire

/* File: uhie_pkg.sv */
// uhie_pkg: constants for the host interrupt enable and frame index block
`default_nettype none

package uhie_pkg;

  // ---------------------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------------------
  localparam int              ADDR_W        = 12;        // apb address width
  localparam logic [11:0]     OFS_COMMAND   = 12'h020;   // host_command
  localparam logic [11:0]     OFS_STATUS    = 12'h024;   // host_status
  localparam logic [11:0]     OFS_INTR_EN   = 12'h028;   // interrupt_enable
  localparam logic [11:0]     OFS_FRAME_IDX = 12'h02c;   // frame_index

  // ---------------------------------------------------------------------------
  // status and enable bit positions (same layout in both registers)
  // ---------------------------------------------------------------------------
  localparam int              BIT_ASYNC_ADV = 5;         // async advance
  localparam int              BIT_SYS_ERR   = 4;         // host system error
  localparam int              BIT_ROLLOVER  = 3;         // frame list rollover
  localparam int              BIT_PORT_CHG  = 2;         // port change
  localparam int              BIT_XFER_ERR  = 1;         // transfer error
  localparam int              BIT_XFER_DONE = 0;         // transfer complete
  localparam int              BIT_HALTED    = 12;        // halted_flag in status
  localparam int              SRC_N         = 6;         // number of sources
  localparam logic [5:0]      DEFER_MASK    = 6'h23;     // wait for threshold
  localparam logic [5:0]      IMMED_MASK    = 6'h1c;     // raised at once

  // ---------------------------------------------------------------------------
  // command register fields
  // ---------------------------------------------------------------------------
  localparam int              BIT_RUN_STOP  = 0;         // run_stop
  localparam int              LSS_LSB       = 2;         // list_size_sel[1:0]
  localparam int              THR_LSB       = 16;        // threshold[7:0]
  localparam logic [1:0]      LSS_1024      = 2'h0;      // 1024 entries
  localparam logic [1:0]      LSS_512       = 2'h1;      // 512 entries
  localparam logic [1:0]      LSS_256       = 2'h2;      // 256 entries

  // ---------------------------------------------------------------------------
  // frame index geometry
  // ---------------------------------------------------------------------------
  localparam int              FIDX_W        = 14;        // implemented bits
  localparam int              ROLL_BIT_1024 = 13;        // toggles on wrap
  localparam int              ROLL_BIT_512  = 12;
  localparam int              ROLL_BIT_256  = 11;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [5:0]      INTR_EN_RST   = 6'h00;
  localparam logic [5:0]      FLAGS_RST     = 6'h00;
  localparam logic [13:0]     FIDX_RST      = 14'h0000;
  localparam logic [7:0]      THRESH_RST    = 8'h08;     // microframes
  localparam logic [1:0]      LSS_RST       = 2'h0;
  localparam logic            RUN_RST       = 1'b0;
  localparam logic            HALTED_RST    = 1'b1;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int              CLK_PERIOD_NS = 20;        // 50 mhz
  localparam int              UFRAME_NS     = 125000;    // 125 us microframe
  localparam int              UFRAME_CYCLES_DFLT = UFRAME_NS / CLK_PERIOD_NS;
  localparam int              UFRAME_CNT_W  = 13;        // holds the default

endpackage : uhie_pkg

`default_nettype wire

/* File: uhie_tick_div.sv */
// uhie_tick_div: enabled modulo counter giving a one-cycle tick
`timescale 1ns/10ps
`default_nettype none

module uhie_tick_div
  import uhie_pkg::*;
#(
  parameter int W = 8                            // counter width
) (
  input  wire logic         clk,                 // controller clock
  input  wire logic         reset,               // async, active high
  input  wire logic         clear,               // restart from zero
  input  wire logic         enable,              // count this cycle
  input  wire logic [W-1:0] last,                // terminal count
  output logic              tick                 // one cycle at terminal
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] cnt;                           // running count
  } uhie_div_s;

  uhie_div_s st_q;                               // registered state
  uhie_div_s st_d;                               // next state

  // >= so a shrunk terminal count still wraps at once
  assign tick = enable && !clear && (st_q.cnt >= last);

  // next count: hold, step or wrap
  always_comb begin
    st_d = st_q;
    if (clear) begin
      st_d.cnt = '0;
    end else if (enable) begin
      st_d.cnt = tick ? '0 : st_q.cnt + W'(1);
    end
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : uhie_tick_div

`default_nettype wire

/* File: tb_usb_host_intr_enable_frame_index.sv */
// tb_usb_host_intr_enable_frame_index: self-checking bench for the irq enable and frame index
`timescale 1ns/10ps
`default_nettype none

module tb_usb_host_intr_enable_frame_index;
  import uhie_pkg::*;

  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic              clk;         // 50 mhz clock
  logic              reset;       // async, active high
  logic              psel;        // apb select
  logic              penable;     // apb access phase
  logic              pwrite;      // apb direction
  logic [ADDR_W-1:0] paddr;       // apb byte address
  logic [31:0]       pwdata;      // apb write data
  logic [31:0]       prdata;      // apb read data
  logic              pready;      // apb ready
  logic              pslverr;     // apb error
  logic [5:0]        evt;         // event pulses, status bit layout
  logic              host_irq;    // host interrupt
  logic [9:0]        list_index;  // periodic list entry
  logic [10:0]       sof_frame_number; // sof frame number
  logic [31:0]       rd;          // last read data
  logic              err;         // last error response
  int                n_mismatch;  // mismatches seen
  int                n_tests;     // comparisons made
  int                cyc;         // cycles run
  int                i;           // wait counter

  // ---------------------------------------------------------------------------
  // device under test, microframe shortened to 8 cycles
  // ---------------------------------------------------------------------------
  uhie_top #(.UFRAME_CYCLES(8)) dut_u (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .async_advance_evt(evt[5]), .system_error_evt(evt[4]), .port_change_evt(evt[2]),
    .transfer_error_evt(evt[1]), .transfer_done_evt(evt[0]), .host_irq(host_irq),
    .list_index(list_index), .sof_frame_number(sof_frame_number));

  // clock generator
  always #10 clk = ~clk;

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer, waits for pready at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // this wait ends once pready is high; the bench timeout guards it
    while (pready !== 1'b1) @(posedge clk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one-cycle event pulse on the given source
  task automatic pulse(input int b);
    @(posedge clk);
    evt[b] <= 1'b1;
    @(posedge clk);
    evt    <= 6'h00;
  endtask : pulse

  // let edges pass, then sample settled outputs
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  // closing report
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // timeout guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    evt = 6'h00; n_mismatch = 0; n_tests = 0; cyc = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    // reset values, unmapped address
    apb(0, OFS_INTR_EN, 0);    chk(rd, 32'h0000_0000);
    chk({pready, err}, 32'h0000_0002);
    apb(0, OFS_FRAME_IDX, 0);  chk(rd, 32'h0000_0000);
    apb(0, OFS_STATUS, 0);     chk(rd, 32'h0000_1000);
    apb(0, 12'h030, 0);        chk({rd[30:0], err}, 32'h0000_0001);
    apb(1, OFS_INTR_EN, 32'h3f);
    apb(0, OFS_INTR_EN, 0); chk(rd, 32'h0000_003f);
    $display("test reset and map done");
    // immediate sources system error and port change raise and drop at once
    apb(1, OFS_INTR_EN, 32'h1c);
    for (int b = 4; b >= 2; b -= 2) begin
      pulse(b); wait_cyc(2); chk(host_irq, 1);
      apb(1, OFS_STATUS, 32'h1 << b); wait_cyc(2); chk(host_irq, 0);
    end
    // masked source still shows in status
    apb(1, OFS_INTR_EN, 32'h00);
    pulse(2); wait_cyc(3); chk(host_irq, 0);
    apb(0, OFS_STATUS, 0); chk(rd, 32'h0000_1004);
    apb(1, OFS_STATUS, 32'h3f);
    $display("test immediate and mask done");
    // halted frame index write reaches sof and list index
    // full word, written while halted and stopped; first step rolls the list
    apb(1, OFS_FRAME_IDX, 32'h1fff);
    apb(0, OFS_FRAME_IDX, 0); chk(rd, 32'h1fff);
    wait_cyc(1); chk(sof_frame_number, 32'h3ff);
    chk(list_index, 32'h3ff);
    // deferred sources wait for a threshold tick
    apb(1, OFS_INTR_EN, 32'h23);
    pulse(0); pulse(1); pulse(5); wait_cyc(10); chk(host_irq, 0);
    apb(1, OFS_COMMAND, 32'h0001_0001);
    for (i = 0; i < 60 && host_irq !== 1'b1; i++) wait_cyc(1);
    chk(host_irq, 1);
    chk(sof_frame_number, 32'h400);
    chk(list_index, 32'h000);
    apb(0, OFS_STATUS, 0); chk(rd, 32'h0000_002b);
    // write while running is dropped
    apb(1, OFS_FRAME_IDX, 32'h0); apb(0, OFS_FRAME_IDX, 0); chk(rd[13], 1);
    apb(1, OFS_STATUS, 32'h3f); wait_cyc(2); chk(host_irq, 0);
    // the 256-entry list size rolls at a lower bit
    apb(1, OFS_COMMAND, 32'h0001_0008); wait_cyc(2);
    apb(1, OFS_FRAME_IDX, 32'h07ff);
    wait_cyc(1); chk(list_index, 32'h0ff);
    apb(1, OFS_COMMAND, 32'h0001_0009);
    wait_cyc(12); apb(0, OFS_STATUS, 0); chk(rd[3], 1);
    apb(1, OFS_COMMAND, 32'h0001_0008);
    $display("test frame index and threshold done");
    print_verdict();
  end

endmodule : tb_usb_host_intr_enable_frame_index

`default_nettype wire
